// file: design/bmd_defs.svh
// ==========================================================================
`ifndef BMD_DEFS_SVH
`define BMD_DEFS_SVH

// ==========================================================================
// register map, byte addresses
`define BMD_REG_CTRL 8'h00
`define BMD_REG_STATUS 8'h04
`define BMD_REG_EDGES 8'h08

// ==========================================================================
// control and status fields
`define BMD_CTRL_OVR_BIT 0
`define BMD_CTRL_MODE_LSB 1
`define BMD_STAT_MODE_LSB 4
`define BMD_STAT_SW_LSB 6
`define BMD_STAT_EA_BIT 8
`define BMD_STAT_CS_BIT 9
`define BMD_STAT_OE_BIT 10

// ==========================================================================
// map switch settings
`define BMD_MAP_NONE 2'h0
`define BMD_MAP_HIGH 2'h1
`define BMD_MAP_PROGEXT 2'h2
`define BMD_MAP_BOTH 2'h3

// ==========================================================================
// flag decode codes: set code of flag i is base plus i times stride
`define BMD_FLAG_SET_BASE 6'h20
`define BMD_FLAG_STRIDE 6'h04
`define BMD_FLAG_CLR_BIT 6'h02

// ==========================================================================
// bus answers
`define BMD_RESP_OKAY 2'h0
`define BMD_RESP_SLVERR 2'h2

`endif

// file: design/bmd_pkg.sv
// ==========================================================================
// types shared by the glue logic
package bmd_pkg;

    typedef logic [1:0] bmd_map_t;

    // processor side pins, sampled as one group
    typedef struct packed {
        logic [4:0] addr_hi;
        logic read_n;
        logic pstore_n;
        logic proc_clk;
        logic sw_high;
        logic sw_low;
    } bmd_pins_s;

    // memory control outputs
    typedef struct packed {
        logic chip_sel_n;
        logic out_en_n;
        logic ext_prog;
    } bmd_mem_s;

endpackage : bmd_pkg

// file: design/bmd_glue.sv
`timescale 1ns/100ps
`include "bmd_defs.svh"

module bmd_glue import bmd_pkg::*; #(
    parameter int ADDR_W = 8,
    parameter int NUM_FLAGS = 4,
    parameter int EDGE_W = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // processor bus pins
    input wire logic [4:0] addr_hi,
    input wire logic read_strobe_n,
    input wire logic program_store_strobe_n,
    input wire logic processor_clock_out,
    input wire logic map_switch_high,
    input wire logic map_switch_low,
    // memory control and flags
    output logic ram_chip_select_n,
    output logic ram_output_enable_n,
    output logic external_program_access,
    output logic [NUM_FLAGS-1:0] port_flags,
    // axi4-lite write address and data
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ======================================================================
    // parameter checks
    if (ADDR_W < 4 || ADDR_W > 8) begin : g_bad_addr
        $error("bmd_glue: ADDR_W must be 4 to 8");
    end
    if (NUM_FLAGS != 4) begin : g_bad_flags
        $error("bmd_glue: decode serves exactly four flags");
    end
    if (EDGE_W < 1 || EDGE_W > 32) begin : g_bad_edge
        $error("bmd_glue: EDGE_W must be 1 to 32");
    end

    // ======================================================================
    // pin synchronisers
    // all pins are asynchronous to sys_clk; address and strobes are sampled
    // together with the processor clock, so they must be stable a few
    // sys_clk periods around its rising edge
    bmd_pins_s pins_raw;
    bmd_pins_s sync1_reg;
    bmd_pins_s sync2_reg;
    logic proc_clk_prev_reg;
    logic proc_edge;

    assign pins_raw = '{addr_hi: addr_hi, read_n: read_strobe_n,
                        pstore_n: program_store_strobe_n, proc_clk: processor_clock_out,
                        sw_high: map_switch_high, sw_low: map_switch_low};

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_reg <= '1;
            sync2_reg <= '1;
        end else begin
            sync1_reg <= pins_raw;
            sync2_reg <= sync1_reg;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            proc_clk_prev_reg <= 1'b1;
        end else begin
            proc_clk_prev_reg <= sync2_reg.proc_clk;
        end
    end

    assign proc_edge = sync2_reg.proc_clk & ~proc_clk_prev_reg;

    // ======================================================================
    // flag decode
    logic [5:0] decode_vec;
    logic [NUM_FLAGS-1:0] flag_reg;

    assign decode_vec = {sync2_reg.addr_hi, sync2_reg.read_n};

    for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
        localparam logic [5:0] SET_CODE = 6'(`BMD_FLAG_SET_BASE + i * `BMD_FLAG_STRIDE);
        localparam logic [5:0] CLR_CODE = SET_CODE | `BMD_FLAG_CLR_BIT;
        // reset value chosen as zero only so the outputs are defined
        always_ff @(posedge sys_clk or negedge arst_n) begin
            if (!arst_n) begin
                flag_reg[i] <= 1'b0;
            end else if (proc_edge && decode_vec == SET_CODE) begin
                flag_reg[i] <= 1'b1;
            end else if (proc_edge && decode_vec == CLR_CODE) begin
                flag_reg[i] <= 1'b0;
            end
            // otherwise the flag holds
        end
    end

    assign port_flags = flag_reg;

    // ======================================================================
    // edge counter, lets software see that the processor clock is alive
    logic [EDGE_W-1:0] edge_cnt_reg;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            edge_cnt_reg <= '0;
        end else if (proc_edge) begin
            edge_cnt_reg <= edge_cnt_reg + 1'b1;
        end
    end

    // ======================================================================
    // memory map selection
    logic ctrl_ovr_reg;
    bmd_map_t ctrl_mode_reg;
    bmd_map_t map_mode;
    bmd_mem_s mem_next;
    bmd_mem_s mem_reg;
    logic any_strobe;

    // software override exists for bring-up without touching the switches
    assign map_mode = ctrl_ovr_reg ? ctrl_mode_reg : {sync2_reg.sw_high, sync2_reg.sw_low};
    assign any_strobe = ~sync2_reg.read_n | ~sync2_reg.pstore_n;

    always_comb begin
        mem_next = '{chip_sel_n: 1'b1, out_en_n: 1'b1, ext_prog: 1'b0};
        case (map_mode)
            `BMD_MAP_NONE: begin
                mem_next = '{chip_sel_n: 1'b1, out_en_n: 1'b1, ext_prog: 1'b0};
            end
            `BMD_MAP_HIGH: begin
                mem_next.chip_sel_n = ~sync2_reg.addr_hi[4];
                mem_next.out_en_n = ~any_strobe;
                mem_next.ext_prog = 1'b0;
            end
            `BMD_MAP_BOTH: begin
                mem_next = '{chip_sel_n: 1'b0, out_en_n: ~any_strobe, ext_prog: 1'b0};
            end
            `BMD_MAP_PROGEXT: begin
                mem_next = '{chip_sel_n: 1'b0, out_en_n: ~any_strobe, ext_prog: 1'b1};
            end
            default: begin
                mem_next = '{chip_sel_n: 1'b1, out_en_n: 1'b1, ext_prog: 1'b0};
            end
        endcase
    end

    // registered outputs cost one more cycle on top of the synchroniser
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mem_reg <= '{chip_sel_n: 1'b1, out_en_n: 1'b1, ext_prog: 1'b0};
        end else begin
            mem_reg <= mem_next;
        end
    end

    assign ram_chip_select_n = mem_reg.chip_sel_n;
    assign ram_output_enable_n = mem_reg.out_en_n;
    assign external_program_access = mem_reg.ext_prog;

    // ======================================================================
    // axi4-lite write path
    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic aw_hold_reg;
    logic w_hold_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic aw_fire;
    logic w_fire;
    logic wr_do;
    logic aw_hold_next;
    logic w_hold_next;
    logic bvalid_next;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;

    assign aw_fire = s_axi_awvalid & awready_reg;
    assign w_fire = s_axi_wvalid & wready_reg;
    assign wr_do = (aw_hold_reg | aw_fire) & (w_hold_reg | w_fire);
    assign aw_hold_next = (aw_hold_reg | aw_fire) & ~wr_do;
    assign w_hold_next = (w_hold_reg | w_fire) & ~wr_do;
    assign bvalid_next = wr_do | (bvalid_reg & ~s_axi_bready);
    assign wr_addr = 8'(aw_fire ? s_axi_awaddr : awaddr_reg);
    assign wr_data = w_fire ? s_axi_wdata : wdata_reg;
    assign wr_strb = w_fire ? s_axi_wstrb : wstrb_reg;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
        end else begin
            aw_hold_reg <= aw_hold_next;
            w_hold_reg <= w_hold_next;
            bvalid_reg <= bvalid_next;
            awready_reg <= ~aw_hold_next & ~bvalid_next;
            wready_reg <= ~w_hold_next & ~bvalid_next;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
        end else begin
            if (aw_fire) begin
                awaddr_reg <= s_axi_awaddr;
            end
            if (w_fire) begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            bresp_reg <= `BMD_RESP_OKAY;
        end else if (wr_do) begin
            case ({wr_addr[7:2], 2'h0})
                `BMD_REG_CTRL, `BMD_REG_STATUS, `BMD_REG_EDGES: begin
                    bresp_reg <= `BMD_RESP_OKAY;
                end
                default: begin
                    bresp_reg <= `BMD_RESP_SLVERR;
                end
            endcase
        end
    end

    // only the control word is writable; other mapped words ignore writes
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_ovr_reg <= 1'b0;
            ctrl_mode_reg <= `BMD_MAP_NONE;
        end else if (wr_do && {wr_addr[7:2], 2'h0} == `BMD_REG_CTRL && wr_strb[0]) begin
            ctrl_ovr_reg <= wr_data[`BMD_CTRL_OVR_BIT];
            ctrl_mode_reg <= wr_data[`BMD_CTRL_MODE_LSB +: 2];
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // ======================================================================
    // axi4-lite read path
    logic arready_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic ar_fire;
    logic rvalid_next;
    logic [31:0] rd_word;
    logic [1:0] rd_resp;

    assign ar_fire = s_axi_arvalid & arready_reg;
    assign rvalid_next = ar_fire | (rvalid_reg & ~s_axi_rready);

    always_comb begin
        rd_word = 32'h0;
        rd_resp = `BMD_RESP_OKAY;
        case ({s_axi_araddr[ADDR_W-1:2], 2'h0})
            `BMD_REG_CTRL: begin
                rd_word[`BMD_CTRL_OVR_BIT] = ctrl_ovr_reg;
                rd_word[`BMD_CTRL_MODE_LSB +: 2] = ctrl_mode_reg;
            end
            `BMD_REG_STATUS: begin
                rd_word[NUM_FLAGS-1:0] = flag_reg;
                rd_word[`BMD_STAT_MODE_LSB +: 2] = map_mode;
                rd_word[`BMD_STAT_SW_LSB +: 2] = {sync2_reg.sw_high, sync2_reg.sw_low};
                rd_word[`BMD_STAT_EA_BIT] = mem_reg.ext_prog;
                rd_word[`BMD_STAT_CS_BIT] = mem_reg.chip_sel_n;
                rd_word[`BMD_STAT_OE_BIT] = mem_reg.out_en_n;
            end
            `BMD_REG_EDGES: begin
                rd_word[EDGE_W-1:0] = edge_cnt_reg;
            end
            default: begin
                rd_resp = `BMD_RESP_SLVERR;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= rvalid_next;
            arready_reg <= ~rvalid_next;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_reg <= 32'h0;
            rresp_reg <= `BMD_RESP_OKAY;
        end else if (ar_fire) begin
            rdata_reg <= rd_word;
            rresp_reg <= rd_resp;
        end
    end

    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

endmodule : bmd_glue

// file: tb/bmd_glue_checker.sv
`timescale 1ns/100ps
module bmd_glue_checker import bmd_pkg::*; #(
    parameter int NUM_FLAGS = 4
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // processor pins
    input wire logic [4:0] addr_hi,
    input wire logic read_strobe_n,
    input wire logic program_store_strobe_n,
    input wire logic processor_clock_out,
    input wire logic map_switch_high,
    input wire logic map_switch_low,
    // memory control and flags
    input wire logic ram_chip_select_n,
    input wire logic ram_output_enable_n,
    input wire logic external_program_access,
    input wire logic [NUM_FLAGS-1:0] port_flags,
    // register bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // ==========================================================================
    // helpers
    bmd_map_t mode;
    logic [5:0] vec;
    logic [3:0] since_rise;
    assign mode = {map_switch_high, map_switch_low};
    assign vec = {addr_hi, read_strobe_n};
    // saturating, so a flag change long after any clock rise is caught
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            since_rise <= 4'hF;
        end else if ($rose(processor_clock_out)) begin
            since_rise <= 4'h0;
        end else if (since_rise != 4'hF) begin
            since_rise <= since_rise + 4'h1;
        end
    end
    sequence code_seen(logic [5:0] code);
        $rose(processor_clock_out) && vec == code;
    endsequence
    // pins pass two sync flops and an output register
    sequence pipe_full;
        $past(arst_n, 3);
    endsequence
    // ==========================================================================
    // memory decode
    mem_cs_a: assert property (pipe_full |-> ram_chip_select_n == ($past(mode, 3) == 2'h0 ||
        ($past(mode, 3) == 2'h1 && !$past(addr_hi[4], 3)))) else $error("chip select wrong");
    mem_oe_a: assert property (pipe_full |-> ram_output_enable_n == ($past(mode, 3) == 2'h0 ||
        $past(read_strobe_n & program_store_strobe_n, 3))) else $error("output enable wrong");
    mem_ea_a: assert property (pipe_full |-> external_program_access == ($past(mode, 3) == 2'h2))
        else $error("program access wrong");
    // ==========================================================================
    // flags
    for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
        flag_set_a: assert property (code_seen(6'h20 + 6'(4 * i)) |-> ##6 port_flags[i])
            else $error("flag not set");
        flag_clr_a: assert property (code_seen(6'h22 + 6'(4 * i)) |-> ##6 !port_flags[i])
            else $error("flag not cleared");
    end
    flag_hold_a: assert property (port_flags != $past(port_flags) |-> since_rise inside {[4'h2:4'h6]})
        else $error("flag changed without clock");
    // ==========================================================================
    // register bus
    wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("write answer late");
    rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
endmodule : bmd_glue_checker

bind bmd_glue bmd_glue_checker #(.NUM_FLAGS(NUM_FLAGS)) bmd_glue_checker_i (
    .sys_clk(sys_clk), .arst_n(arst_n), .addr_hi(addr_hi), .read_strobe_n(read_strobe_n),
    .program_store_strobe_n(program_store_strobe_n), .processor_clock_out(processor_clock_out),
    .map_switch_high(map_switch_high), .map_switch_low(map_switch_low), .ram_chip_select_n(ram_chip_select_n),
    .ram_output_enable_n(ram_output_enable_n), .external_program_access(external_program_access),
    .port_flags(port_flags), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata)
);

// file: tb/bmd_proc_model.sv
`timescale 1ns/100ps
module bmd_proc_model (
    // clock
    input wire logic sys_clk,
    // processor bus pins
    output logic [4:0] addr_hi,
    output logic read_strobe_n,
    output logic program_store_strobe_n,
    output logic processor_clock_out
);
    initial begin
        addr_hi = 5'h00;
        read_strobe_n = 1'b1;
        program_store_strobe_n = 1'b1;
        processor_clock_out = 1'b0;
    end
    // ==========================================================================
    // one bus cycle, address held well around the clock rise
    task automatic access(input logic [4:0] a, input logic rd_n);
        addr_hi <= a;
        read_strobe_n <= rd_n;
        repeat (4) @(posedge sys_clk);
        processor_clock_out <= 1'b1;
        repeat (4) @(posedge sys_clk);
        processor_clock_out <= 1'b0;
        repeat (4) @(posedge sys_clk);
        read_strobe_n <= 1'b1;
        // released bus must not keep showing the old address
        addr_hi <= ~a;
        @(posedge sys_clk);
    endtask : access
    task automatic hold(input logic [4:0] a, input logic rd_n, input logic ps_n);
        addr_hi <= a;
        read_strobe_n <= rd_n;
        program_store_strobe_n <= ps_n;
    endtask : hold
endmodule : bmd_proc_model

// file: tb/board_memory_decode_glue_test.sv
`timescale 1ns/100ps
module board_memory_decode_glue_test;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic sw_high, sw_low, proc_clk, rd_n, ps_n;
    logic [4:0] addr_hi;
    logic [3:0] port_flags, flags_exp;
    logic cs_n, oe_n, ea;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int errors = 0;
    int tests_run = 0;
    int cycles = 0;
    int edges_exp = 0;
    // when set, rready waits for rvalid so the slave must hold its read answer
    logic late_ready = 1'b0;
    always #5 sys_clk = ~sys_clk;
    bmd_proc_model bmd_proc_model_i (.sys_clk(sys_clk), .addr_hi(addr_hi), .read_strobe_n(rd_n),
        .program_store_strobe_n(ps_n), .processor_clock_out(proc_clk));
    bmd_glue bmd_glue_i (.sys_clk(sys_clk), .arst_n(arst_n), .addr_hi(addr_hi), .read_strobe_n(rd_n),
        .program_store_strobe_n(ps_n), .processor_clock_out(proc_clk), .map_switch_high(sw_high),
        .map_switch_low(sw_low), .ram_chip_select_n(cs_n), .ram_output_enable_n(oe_n),
        .external_program_access(ea), .port_flags(port_flags), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
    // ==========================================================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report
    task automatic do_reset;
        arst_n <= 1'b0;
        repeat (10) @(posedge sys_clk);
        arst_n <= 1'b1;
        flags_exp = 4'h0;
        edges_exp = 0;
        @(posedge sys_clk);
    endtask : do_reset
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        check(32'(s_axi_bresp), 32'(resp));
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
        logic taken;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= !late_ready;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            taken = s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1;
            if (s_axi_rvalid === 1'b1 && !taken) s_axi_rready <= 1'b1;
        end while (!taken);
        // rready stays high between reads; the next call sets it once
        check(s_axi_rdata, d);
        check(32'(s_axi_rresp), 32'(resp));
    endtask : axi_rd
    // bench model of the flags: set and clear codes only
    task automatic flag_access(input logic [4:0] a, input logic r);
        bmd_proc_model_i.access(a, r);
        edges_exp++;
        for (int i = 0; i < 4; i++) begin
            if ({a, r} == 6'(32 + 4 * i)) flags_exp[i] = 1'b1;
            if ({a, r} == 6'(34 + 4 * i)) flags_exp[i] = 1'b0;
        end
        check(32'(port_flags), 32'(flags_exp));
    endtask : flag_access
    // returns chip select, output enable, program access
    function automatic logic [2:0] mem_exp(input logic [1:0] m, input logic a15, input logic idle);
        case (m)
            2'h0: return 3'b110;
            2'h1: return {!a15, idle, 1'b0};
            2'h2: return {1'b0, idle, 1'b1};
            default: return {1'b0, idle, 1'b0};
        endcase
    endfunction : mem_exp
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 8000) begin
            errors++;
            final_report();
        end
    end
    // ==========================================================================
    // main sequence
    initial begin
        {sw_high, sw_low} = 2'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        void'($urandom(32'hE4CB));
        do_reset();
        for (int v = 0; v < 32; v++) begin
            {sw_high, sw_low} <= v[4:3];
            bmd_proc_model_i.hold({v[2], 4'($urandom)}, v[1], v[0]);
            repeat (5) @(posedge sys_clk);
            check(32'({cs_n, oe_n, ea}), 32'(mem_exp(v[4:3], v[2], v[1] & v[0])));
        end
        {sw_high, sw_low} <= 2'h2;
        for (int i = 0; i < 4; i++) begin
            flag_access(5'(16 + 2 * i), 1'b0);
            flag_access(5'(17 + 2 * i), 1'b1);
            flag_access(5'(17 + 2 * i), 1'b0);
            flag_access(5'(16 + 2 * i), 1'b0);
        end
        repeat (60) flag_access(5'($urandom), 1'($urandom));
        axi_wr(8'h00, 32'h6, 2'h0);
        axi_rd(8'h00, 32'h6, 2'h0);
        axi_wr(8'h04, 32'hFFFFFFFF, 2'h0);
        axi_rd(8'h04, {21'h0, 1'b1, 1'b0, 1'b1, 2'h2, 2'h2, flags_exp}, 2'h0);
        late_ready = 1'b1;
        axi_rd(8'h08, {16'h0, 16'(edges_exp)}, 2'h0);
        axi_wr(8'h0C, 32'h1, 2'h2);
        axi_rd(8'h0C, 32'h0, 2'h2);
        do_reset();
        check(32'(port_flags), 32'h0);
        axi_rd(8'h08, 32'h0, 2'h0);
        final_report();
    end
endmodule : board_memory_decode_glue_test
